// >>> fmd_datapath.sv
// Fractional multiply-accumulate datapath with two accumulators and barrel shifter.
// Assumes the sequencer drives one-cycle operation and move requests synchronously.
//
// Overview of operation
// RL1 - Four 24-bit input registers feed the multiplier and adder.
// RL2 - Six part registers form two 56-bit accumulators of guard, upper and lower.
// RL3 - Any register can be moved to or from either data bus as 24 or 48 bits.
// RL4 - Arithmetic sources come only from the datapath's own registers.
// RL5 - Every operation result lands in one of the two accumulators; here a bus write to that accumulator in the same cycle overrides it.
// RL6 - Operations take two pipelined cycles and one may start every clock.
// RL7 - A result is forwarded so the next operation uses it without stall.
// RL8 - The MAC takes up to three operands and yields one 56-bit result.
// RL9 - The multiplier handles signed, unsigned and mixed fractional operands.
// RL10 - The 48-bit product is right-justified and added to the full accumulator.
// RL11 - A result stores as 24 bits, truncated unless rounding is asked for.
// RL12 - A mode input selects 24-bit or 16-bit arithmetic.
// RL13 - A 56-bit barrel shifter gives shifts, normalization and bit-field extract.
// RL14 - Two limiters, one per bus, let both buses read accumulators together.
// RL15 - An accumulator out of range on a bus move is replaced by the limit value.
`timescale 1ns/1ps
module fmd_datapath #(
   parameter int WORD_W = 24,
   parameter int ACC_W  = 56
) (
   input  wire logic                i_clock,
   input  wire logic                i_rst_b,
   input  wire logic                i_half_mode,
   input  wire logic                i_op_valid,
   input  wire logic [2:0]          i_op,
   input  wire logic [3:0]          i_src_a,
   input  wire logic [3:0]          i_src_b,
   input  wire logic                i_dst_acc,
   input  wire logic                i_add_acc,
   input  wire logic [1:0]          i_sign,
   input  wire logic                i_round,
   input  wire logic                i_negate,
   input  wire logic [5:0]          i_shift,
   input  wire logic                i_bus1_wr,
   input  wire logic [3:0]          i_bus1_wsel,
   input  wire logic [2*WORD_W-1:0] i_bus1_wdata,
   input  wire logic                i_bus2_wr,
   input  wire logic [3:0]          i_bus2_wsel,
   input  wire logic [2*WORD_W-1:0] i_bus2_wdata,
   input  wire logic                i_bus1_rd,
   input  wire logic [3:0]          i_bus1_rsel,
   input  wire logic                i_bus2_rd,
   input  wire logic [3:0]          i_bus2_rsel,
   output logic      [2*WORD_W-1:0] o_bus1_rdata,
   output logic      [2*WORD_W-1:0] o_bus2_rdata,
   output logic                     o_bus1_limited,
   output logic                     o_bus2_limited,
   output logic                     o_result_valid,
   output logic      [ACC_W-1:0]    o_result,
   output logic      [WORD_W-1:0]   o_result_word
);
   localparam int PROD_W = 2 * WORD_W;

   // RL1 four input registers
   logic [WORD_W-1:0] op_q [4];
   // RL2 two 56-bit accumulators
   logic [ACC_W-1:0]  acc_q [2];

   // Stage-one pipeline registers
   logic [PROD_W:0]   prod_q;
   logic [ACC_W-1:0]  base_q;
   logic [ACC_W-1:0]  alt_q;
   logic [2:0]        op_q1;
   logic              dst_q1;
   logic              round_q1;
   logic              neg_q1;
   logic [5:0]        shift_q1;
   logic              half_q1;
   fmd_pkg::fmd_st_t  st_q;

   logic [ACC_W-1:0]  res_d;
   logic [ACC_W-1:0]  acc_fwd [2];
   logic [ACC_W-1:0]  src_a;
   logic [ACC_W-1:0]  src_b;
   logic [PROD_W:0]   prod_d;
   logic [PROD_W-1:0] lim1;
   logic [PROD_W-1:0] lim2;
   logic              lim1_f;
   logic              lim2_f;

   // RL7 forward stage-two result
   always_comb begin
      acc_fwd[0] = acc_q[0];
      acc_fwd[1] = acc_q[1];
      if (st_q == fmd_pkg::FMD_ST_BUSY) begin
         acc_fwd[dst_q1] = res_d;
      end
   end

   // RL4 sources from own registers
   function automatic logic [ACC_W-1:0] pick(input logic [3:0] sel,
                                              input logic [ACC_W-1:0] a0,
                                              input logic [ACC_W-1:0] a1);
      logic [ACC_W-1:0] v;
      v = '0;
      case (sel)
         fmd_pkg::FMD_SEL_OP1_LOWER: v = {{(ACC_W-WORD_W){op_q[0][WORD_W-1]}}, op_q[0]};
         fmd_pkg::FMD_SEL_OP1_UPPER: v = {{(ACC_W-WORD_W){op_q[1][WORD_W-1]}}, op_q[1]};
         fmd_pkg::FMD_SEL_OP2_LOWER: v = {{(ACC_W-WORD_W){op_q[2][WORD_W-1]}}, op_q[2]};
         fmd_pkg::FMD_SEL_OP2_UPPER: v = {{(ACC_W-WORD_W){op_q[3][WORD_W-1]}}, op_q[3]};
         fmd_pkg::FMD_SEL_ACC1_FULL: v = a0;
         fmd_pkg::FMD_SEL_ACC2_FULL: v = a1;
         fmd_pkg::FMD_SEL_OP1_FULL:
            v = {{(ACC_W-PROD_W){op_q[1][WORD_W-1]}}, op_q[1], op_q[0]};
         fmd_pkg::FMD_SEL_OP2_FULL:
            v = {{(ACC_W-PROD_W){op_q[3][WORD_W-1]}}, op_q[3], op_q[2]};
         default: v = '0;
      endcase
      return v;
   endfunction

   // RL9 signed, unsigned, mixed
   always_comb begin
      logic signed [WORD_W:0] ma;
      logic signed [WORD_W:0] mb;
      logic signed [2*WORD_W+1:0] p;
      ma = '0;
      mb = '0;
      p  = '0;
      src_a = pick(i_src_a, acc_fwd[0], acc_fwd[1]);
      src_b = pick(i_src_b, acc_fwd[0], acc_fwd[1]);
      case (i_sign)
         fmd_pkg::FMD_SIGN_UU: begin
            ma = {1'b0, src_a[WORD_W-1:0]};
            mb = {1'b0, src_b[WORD_W-1:0]};
         end
         fmd_pkg::FMD_SIGN_SU: begin
            ma = {src_a[WORD_W-1], src_a[WORD_W-1:0]};
            mb = {1'b0, src_b[WORD_W-1:0]};
         end
         default: begin
            ma = {src_a[WORD_W-1], src_a[WORD_W-1:0]};
            mb = {src_b[WORD_W-1], src_b[WORD_W-1:0]};
         end
      endcase
      p = ma * mb;
      // Fractional: drop the duplicated sign by one left shift
      prod_d = {p[2*WORD_W+1], p[PROD_W-2:0], 1'b0};
   end

   // RL6 stage one register
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prod_q   <= '0;
         base_q   <= fmd_pkg::ACC_RESET;
         alt_q    <= fmd_pkg::ACC_RESET;
         op_q1    <= fmd_pkg::FMD_OP_NOP;
         dst_q1   <= 1'b0;
         round_q1 <= 1'b0;
         neg_q1   <= 1'b0;
         shift_q1 <= fmd_pkg::SHIFT_ZERO;
         half_q1  <= 1'b0;
         st_q     <= fmd_pkg::FMD_ST_IDLE;
      end else begin
         st_q     <= i_op_valid ? fmd_pkg::FMD_ST_BUSY : fmd_pkg::FMD_ST_IDLE;
         prod_q   <= prod_d;
         // RL8 third operand is accumulator
         base_q   <= i_add_acc ? acc_fwd[i_dst_acc] : fmd_pkg::ACC_RESET;
         alt_q    <= src_a;
         op_q1    <= i_op;
         dst_q1   <= i_dst_acc;
         round_q1 <= i_round;
         neg_q1   <= i_negate;
         shift_q1 <= i_shift;
         half_q1  <= i_half_mode;
      end
   end

   // RL10 right-justified add
   always_comb begin
      logic [ACC_W-1:0] pe;
      logic [ACC_W-1:0] sum;
      logic [ACC_W-1:0] rc;
      int               lz;
      pe  = {{(ACC_W-PROD_W){prod_q[PROD_W]}}, prod_q[PROD_W-1:0]};
      pe  = neg_q1 ? ACC_W'(-pe) : pe;
      sum = '0;
      rc  = '0;
      lz  = 0;
      case (op_q1)
         fmd_pkg::FMD_OP_MPY,
         fmd_pkg::FMD_OP_MAC: sum = base_q + pe;
         fmd_pkg::FMD_OP_ADD: sum = base_q + alt_q;
         // RL13 barrel shifter ops
         fmd_pkg::FMD_OP_SHL: sum = alt_q << shift_q1;
         fmd_pkg::FMD_OP_SHR: sum = ACC_W'($signed(alt_q) >>> shift_q1);
         fmd_pkg::FMD_OP_NRM: begin
            for (int k = ACC_W-2; k >= 0; k--) begin
               if (lz == 0 && alt_q[k] != alt_q[ACC_W-1]) begin
                  lz = ACC_W - 2 - k;
               end
            end
            sum = alt_q << lz;
         end
         fmd_pkg::FMD_OP_EXT: sum = (alt_q >> shift_q1) & ((ACC_W'(1) << WORD_W) - 1'b1);
         default: sum = base_q;
      endcase
      // RL11 round only on request
      if (round_q1) begin
         rc  = half_q1 ? fmd_pkg::ROUND_HALF16 : fmd_pkg::ROUND_HALF;
         sum = sum + rc;
         // RL12 16-bit clears more low bits
         if (half_q1) begin
            sum[fmd_pkg::UPPER_LSB+7:0] = '0;
         end else begin
            sum[fmd_pkg::UPPER_LSB-1:0] = '0;
         end
      end
      res_d = sum;
   end

   // RL5 result into accumulator
   // RL3 bus writes into registers
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < 2; i++) begin
            acc_q[i] <= fmd_pkg::ACC_RESET;
         end
         for (int i = 0; i < 4; i++) begin
            op_q[i] <= fmd_pkg::WORD_RESET;
         end
      end else begin
         if (st_q == fmd_pkg::FMD_ST_BUSY) begin
            acc_q[dst_q1] <= res_d;
         end
         if (i_bus1_wr) begin
            bus_write(i_bus1_wsel, i_bus1_wdata);
         end
         if (i_bus2_wr) begin
            bus_write(i_bus2_wsel, i_bus2_wdata);
         end
      end
   end

   task automatic bus_write(input logic [3:0] sel, input logic [PROD_W-1:0] d);
      case (sel)
         fmd_pkg::FMD_SEL_OP1_LOWER: op_q[0] <= d[WORD_W-1:0];
         fmd_pkg::FMD_SEL_OP1_UPPER: op_q[1] <= d[WORD_W-1:0];
         fmd_pkg::FMD_SEL_OP2_LOWER: op_q[2] <= d[WORD_W-1:0];
         fmd_pkg::FMD_SEL_OP2_UPPER: op_q[3] <= d[WORD_W-1:0];
         fmd_pkg::FMD_SEL_OP1_FULL: begin
            op_q[1] <= d[PROD_W-1:WORD_W];
            op_q[0] <= d[WORD_W-1:0];
         end
         fmd_pkg::FMD_SEL_OP2_FULL: begin
            op_q[3] <= d[PROD_W-1:WORD_W];
            op_q[2] <= d[WORD_W-1:0];
         end
         fmd_pkg::FMD_SEL_ACC1_LOWER: acc_q[0][WORD_W-1:0] <= d[WORD_W-1:0];
         fmd_pkg::FMD_SEL_ACC2_LOWER: acc_q[1][WORD_W-1:0] <= d[WORD_W-1:0];
         fmd_pkg::FMD_SEL_ACC1_GUARD: acc_q[0][ACC_W-1:PROD_W] <= d[ACC_W-PROD_W-1:0];
         fmd_pkg::FMD_SEL_ACC2_GUARD: acc_q[1][ACC_W-1:PROD_W] <= d[ACC_W-PROD_W-1:0];
         // Upper write sign-extends into guard and clears lower
         fmd_pkg::FMD_SEL_ACC1_UPPER:
            acc_q[0] <= {{(ACC_W-PROD_W){d[WORD_W-1]}}, d[WORD_W-1:0], {WORD_W{1'b0}}};
         fmd_pkg::FMD_SEL_ACC2_UPPER:
            acc_q[1] <= {{(ACC_W-PROD_W){d[WORD_W-1]}}, d[WORD_W-1:0], {WORD_W{1'b0}}};
         fmd_pkg::FMD_SEL_ACC1_FULL:
            acc_q[0] <= {{(ACC_W-PROD_W){d[PROD_W-1]}}, d};
         fmd_pkg::FMD_SEL_ACC2_FULL:
            acc_q[1] <= {{(ACC_W-PROD_W){d[PROD_W-1]}}, d};
         default: ;
      endcase
   endtask

   // RL14 one limiter per bus
   fmd_limiter #(.ACC_W(ACC_W), .WORD_W(WORD_W)) u_lim1 (
      .i_acc       (i_bus1_rsel == fmd_pkg::FMD_SEL_ACC2_UPPER ||
                    i_bus1_rsel == fmd_pkg::FMD_SEL_ACC2_FULL ? acc_q[1] : acc_q[0]),
      .i_half_mode (i_half_mode),
      .i_double    (i_bus1_rsel == fmd_pkg::FMD_SEL_ACC1_FULL ||
                    i_bus1_rsel == fmd_pkg::FMD_SEL_ACC2_FULL),
      .o_bus       (lim1),
      .o_limited   (lim1_f)
   );
   fmd_limiter #(.ACC_W(ACC_W), .WORD_W(WORD_W)) u_lim2 (
      .i_acc       (i_bus2_rsel == fmd_pkg::FMD_SEL_ACC2_UPPER ||
                    i_bus2_rsel == fmd_pkg::FMD_SEL_ACC2_FULL ? acc_q[1] : acc_q[0]),
      .i_half_mode (i_half_mode),
      .i_double    (i_bus2_rsel == fmd_pkg::FMD_SEL_ACC1_FULL ||
                    i_bus2_rsel == fmd_pkg::FMD_SEL_ACC2_FULL),
      .o_bus       (lim2),
      .o_limited   (lim2_f)
   );

   function automatic logic [PROD_W:0] rd_mux(input logic [3:0] sel,
                                              input logic [PROD_W-1:0] lim,
                                              input logic lf);
      logic [PROD_W:0] r;
      r = '0;
      case (sel)
         fmd_pkg::FMD_SEL_ACC1_UPPER, fmd_pkg::FMD_SEL_ACC2_UPPER,
         fmd_pkg::FMD_SEL_ACC1_FULL, fmd_pkg::FMD_SEL_ACC2_FULL: r = {lf, lim};
         fmd_pkg::FMD_SEL_OP1_FULL: r = {1'b0, op_q[1], op_q[0]};
         fmd_pkg::FMD_SEL_OP2_FULL: r = {1'b0, op_q[3], op_q[2]};
         fmd_pkg::FMD_SEL_ACC1_LOWER: r = {{(WORD_W+1){1'b0}}, acc_q[0][WORD_W-1:0]};
         fmd_pkg::FMD_SEL_ACC2_LOWER: r = {{(WORD_W+1){1'b0}}, acc_q[1][WORD_W-1:0]};
         // Guard read sign-extends to a full word
         fmd_pkg::FMD_SEL_ACC1_GUARD:
            r = {{(WORD_W+1){1'b0}}, {(PROD_W-ACC_W+WORD_W){acc_q[0][ACC_W-1]}},
                 acc_q[0][ACC_W-1:PROD_W]};
         fmd_pkg::FMD_SEL_ACC2_GUARD:
            r = {{(WORD_W+1){1'b0}}, {(PROD_W-ACC_W+WORD_W){acc_q[1][ACC_W-1]}},
                 acc_q[1][ACC_W-1:PROD_W]};
         fmd_pkg::FMD_SEL_OP1_LOWER: r = {{(WORD_W+1){1'b0}}, op_q[0]};
         fmd_pkg::FMD_SEL_OP1_UPPER: r = {{(WORD_W+1){1'b0}}, op_q[1]};
         fmd_pkg::FMD_SEL_OP2_LOWER: r = {{(WORD_W+1){1'b0}}, op_q[2]};
         fmd_pkg::FMD_SEL_OP2_UPPER: r = {{(WORD_W+1){1'b0}}, op_q[3]};
         default: r = '0;
      endcase
      return r;
   endfunction

   // RL15 registered limited reads
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_bus1_rdata   <= '0;
         o_bus2_rdata   <= '0;
         o_bus1_limited <= 1'b0;
         o_bus2_limited <= 1'b0;
      end else begin
         if (i_bus1_rd) begin
            {o_bus1_limited, o_bus1_rdata} <= rd_mux(i_bus1_rsel, lim1, lim1_f);
         end
         if (i_bus2_rd) begin
            {o_bus2_limited, o_bus2_rdata} <= rd_mux(i_bus2_rsel, lim2, lim2_f);
         end
      end
   end

   // RL11 truncated word view
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_result_valid <= 1'b0;
         o_result       <= fmd_pkg::ACC_RESET;
         o_result_word  <= fmd_pkg::WORD_RESET;
      end else begin
         o_result_valid <= (st_q == fmd_pkg::FMD_ST_BUSY);
         if (st_q == fmd_pkg::FMD_ST_BUSY) begin
            o_result      <= res_d;
            o_result_word <= res_d[fmd_pkg::UPPER_LSB +: WORD_W];
         end
      end
   end
endmodule

// >>> fmd_datapath_sva.sv
// Checker for the MAC datapath ports: result timing, read hold, limiter values.
// Assumes it is bound onto the datapath top; one clock, active-low async reset.
`timescale 1ns/1ps
module fmd_chk #(
   parameter int WORD_W = 24,
   parameter int ACC_W  = 56
) (
   input wire logic                i_clock,
   input wire logic                i_rst_b,
   input wire logic                i_half_mode,
   input wire logic                i_op_valid,
   input wire logic [2:0]          i_op,
   input wire logic                i_bus1_rd,
   input wire logic                i_bus2_rd,
   input wire logic [2*WORD_W-1:0] o_bus1_rdata,
   input wire logic [2*WORD_W-1:0] o_bus2_rdata,
   input wire logic                o_bus1_limited,
   input wire logic                o_bus2_limited,
   input wire logic                o_result_valid,
   input wire logic [ACC_W-1:0]    o_result,
   input wire logic [WORD_W-1:0]   o_result_word
);
   logic opv;
   // A valid nop still raises a result in the datapath, but it is left out of the result timing
   assign opv = i_op_valid && (i_op != 3'h0);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   chk_result_latency: assert property (opv |-> ##2 o_result_valid)
      else $error("result valid missing two cycles after an operation");
   chk_result_cause: assert property (o_result_valid |-> $past(opv, 2))
      else $error("result valid without an operation two cycles before");
   chk_valid_single: assert property (o_result_valid && !$past(opv) |=> !o_result_valid)
      else $error("result valid longer than its operations");
   chk_word_field: assert property (o_result_valid |-> o_result_word == o_result[47:24])
      else $error("result word is not the upper field of the result");
   chk_guard_sign: assert property (opv && i_op == 3'h1 |-> ##2 o_result[ACC_W-1:ACC_W-8] inside {8'h00, 8'hff})
      else $error("multiply result guard is not an extension");
   chk_rd1_hold: assert property (!i_bus1_rd |=> $stable({o_bus1_rdata, o_bus1_limited}))
      else $error("bus one read data changed without a read");
   chk_rd2_hold: assert property (!i_bus2_rd |=> $stable({o_bus2_rdata, o_bus2_limited}))
      else $error("bus two read data changed without a read");
   chk_lim1_value: assert property (o_bus1_limited && !i_half_mode |-> o_bus1_rdata inside
      {48'h7fffff_ffffff, 48'h800000_000000, 48'h000000_7fffff, 48'h000000_800000})
      else $error("bus one limited value is not a limit");
   chk_lim2_value: assert property (o_bus2_limited && !i_half_mode |-> o_bus2_rdata inside
      {48'h7fffff_ffffff, 48'h800000_000000, 48'h000000_7fffff, 48'h000000_800000})
      else $error("bus two limited value is not a limit");
   cov_back_to_back: cover property (o_result_valid ##1 o_result_valid);
   cov_both_reads: cover property (i_bus1_rd && i_bus2_rd);
   cov_lim1: cover property (o_bus1_limited);
   cov_lim2: cover property (o_bus2_limited);
endmodule

// >>> fmd_limiter.sv
// Bus shifter/limiter between one accumulator and one data bus.
// Assumes the caller registers the result; purely combinational here.
`timescale 1ns/1ps
module fmd_limiter #(
   parameter int ACC_W  = 56,
   parameter int WORD_W = 24
) (
   input  wire logic [ACC_W-1:0]    i_acc,
   input  wire logic                i_half_mode,
   input  wire logic                i_double,
   output logic      [2*WORD_W-1:0] o_bus,
   output logic                     o_limited
);
   logic             ovf;
   logic             ovf16;
   logic             neg;

   // RL15 saturate on guard use
   always_comb begin
      neg   = i_acc[ACC_W-1];
      // Guard bits plus upper msb must all agree, else value is out of range
      ovf   = !(&i_acc[ACC_W-1:2*WORD_W-1] || ~|i_acc[ACC_W-1:2*WORD_W-1]);
      ovf16 = !(&i_acc[ACC_W-1:2*WORD_W-9] || ~|i_acc[ACC_W-1:2*WORD_W-9]);
      o_limited = i_half_mode ? ovf16 : ovf;
      if (!o_limited) begin
         o_bus = i_double ? i_acc[2*WORD_W-1:0] : {{WORD_W{1'b0}}, i_acc[2*WORD_W-1:WORD_W]};
      end else if (i_double) begin
         o_bus = neg ? {1'b1, {(2*WORD_W-1){1'b0}}} : {1'b0, {(2*WORD_W-1){1'b1}}};
      end else begin
         o_bus = {{WORD_W{1'b0}}, neg, {(WORD_W-1){!neg}}};
      end
   end
endmodule

// >>> fmd_pkg.sv
// Package for the fractional MAC datapath: widths, field positions, selectors.
// Assumes a single core clock; shared by the datapath and its testbench.
package fmd_pkg;
   localparam int WORD_W  = 24;
   localparam int GUARD_W = 8;
   localparam int ACC_W   = 56;
   localparam int PROD_W  = 48;
   localparam int HALF_W  = 16;
   // Field positions inside a 56-bit accumulator
   localparam int LOWER_LSB = 0;
   localparam int UPPER_LSB = 24;
   localparam int GUARD_LSB = 48;
   // Rounding constant: half of one upper-field unit
   localparam logic [ACC_W-1:0] ROUND_HALF = 56'h00_000000_800000;
   localparam logic [ACC_W-1:0] ROUND_HALF16 = 56'h00_008000_000000;
   localparam logic [ACC_W-1:0] ACC_RESET = 56'h00_000000_000000;
   localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
   localparam logic [5:0] SHIFT_ZERO = 6'h00;

   // Register selectors for bus moves and operand sources
   typedef enum logic [3:0] {
      FMD_SEL_OP1_LOWER = 4'h0,
      FMD_SEL_OP1_UPPER = 4'h1,
      FMD_SEL_OP2_LOWER = 4'h2,
      FMD_SEL_OP2_UPPER = 4'h3,
      FMD_SEL_ACC1_LOWER = 4'h4,
      FMD_SEL_ACC1_UPPER = 4'h5,
      FMD_SEL_ACC1_GUARD = 4'h6,
      FMD_SEL_ACC2_LOWER = 4'h7,
      FMD_SEL_ACC2_UPPER = 4'h8,
      FMD_SEL_ACC2_GUARD = 4'h9,
      FMD_SEL_ACC1_FULL  = 4'ha,
      FMD_SEL_ACC2_FULL  = 4'hb,
      FMD_SEL_OP1_FULL   = 4'hc,
      FMD_SEL_OP2_FULL   = 4'hd
   } fmd_sel_t;

   // Operations accepted by the datapath
   typedef enum logic [2:0] {
      FMD_OP_NOP = 3'h0,
      FMD_OP_MPY = 3'h1,
      FMD_OP_MAC = 3'h2,
      FMD_OP_ADD = 3'h3,
      FMD_OP_SHL = 3'h4,
      FMD_OP_SHR = 3'h5,
      FMD_OP_NRM = 3'h6,
      FMD_OP_EXT = 3'h7
   } fmd_op_t;

   // Operand signedness for the multiplier
   typedef enum logic [1:0] {
      FMD_SIGN_SS = 2'h0,
      FMD_SIGN_UU = 2'h1,
      FMD_SIGN_SU = 2'h2
   } fmd_sign_t;

   // Pipeline stage occupancy, one-hot
   typedef enum logic [1:0] {
      FMD_ST_IDLE = 2'b01,
      FMD_ST_BUSY = 2'b10
   } fmd_st_t;
endpackage

// >>> fmd_seq_model.sv
// Sequencer and memory data bus model issuing operations and register moves.
// Assumes tasks are entered 1 ns after a rising edge; each returns likewise.
`timescale 1ns/1ps
module fmd_seq_model (
   input  wire logic   i_clock,
   output logic        o_half_mode,
   output logic        o_op_valid,
   output logic [2:0]  o_op,
   output logic [3:0]  o_src_a,
   output logic [3:0]  o_src_b,
   output logic        o_dst_acc,
   output logic        o_add_acc,
   output logic [1:0]  o_sign,
   output logic        o_round,
   output logic        o_negate,
   output logic [5:0]  o_shift,
   output logic        o_bus1_wr,
   output logic [3:0]  o_bus1_wsel,
   output logic [47:0] o_bus1_wdata,
   output logic        o_bus2_wr,
   output logic [3:0]  o_bus2_wsel,
   output logic [47:0] o_bus2_wdata,
   output logic        o_bus1_rd,
   output logic [3:0]  o_bus1_rsel,
   output logic        o_bus2_rd,
   output logic [3:0]  o_bus2_rsel
);
   initial begin
      {o_half_mode, o_op_valid, o_op, o_src_a, o_src_b, o_dst_acc, o_add_acc} = '0;
      {o_sign, o_round, o_negate, o_shift, o_bus1_wr, o_bus1_wsel, o_bus1_wdata} = '0;
      {o_bus2_wr, o_bus2_wsel, o_bus2_wdata, o_bus1_rd, o_bus1_rsel, o_bus2_rd, o_bus2_rsel} = '0;
   end
   task automatic step();
      @(posedge i_clock);
      #1;
   endtask
   // Requests stay up across calls; only idle drops them
   task automatic op(input logic [2:0] code, input logic [3:0] a, input logic [3:0] b,
                     input logic dst, input logic add, input logic [1:0] sg,
                     input logic rnd, input logic neg);
      {o_op_valid, o_op, o_src_a, o_src_b} = {1'b1, code, a, b};
      {o_dst_acc, o_add_acc, o_sign, o_round, o_negate} = {dst, add, sg, rnd, neg};
      step();
   endtask
   task automatic wr(input logic bus, input logic [3:0] sel, input logic [47:0] data);
      if (bus) {o_bus2_wr, o_bus2_wsel, o_bus2_wdata} = {1'b1, sel, data};
      else {o_bus1_wr, o_bus1_wsel, o_bus1_wdata} = {1'b1, sel, data};
      step();
   endtask
   task automatic rd(input logic [3:0] s1, input logic [3:0] s2);
      {o_bus1_rd, o_bus1_rsel, o_bus2_rd, o_bus2_rsel} = {1'b1, s1, 1'b1, s2};
      step();
   endtask
   task automatic idle();
      {o_op_valid, o_bus1_wr, o_bus2_wr, o_bus1_rd, o_bus2_rd} = 5'h00;
      // Released op code and write data lines invert so a stale value can never pass for a held one
      {o_op, o_bus1_wdata, o_bus2_wdata} = ~{o_op, o_bus1_wdata, o_bus2_wdata};
      step();
   endtask
endmodule

// >>> fmd_tb.sv
// Self-checking bench for the MAC datapath: products, forwarding, rounding, limiters.
// Assumes the sequencer model drives every request input of the datapath.
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
   logic        i_clock, i_rst_b, i_half_mode, i_op_valid, i_dst_acc, i_add_acc, i_round;
   logic        i_negate, i_bus1_wr, i_bus2_wr, i_bus1_rd, i_bus2_rd;
   logic [2:0]  i_op;
   logic [3:0]  i_src_a, i_src_b, i_bus1_wsel, i_bus2_wsel, i_bus1_rsel, i_bus2_rsel;
   logic [1:0]  i_sign;
   logic [5:0]  i_shift;
   logic [47:0] i_bus1_wdata, i_bus2_wdata, o_bus1_rdata, o_bus2_rdata;
   logic        o_bus1_limited, o_bus2_limited, o_result_valid;
   logic [55:0] o_result;
   logic [23:0] o_result_word;
   int          n_errors = 0;
   int          check_count = 0;
   fmd_datapath dut_u (.*);
   fmd_seq_model seq_u (.i_clock(i_clock), .o_half_mode(i_half_mode), .o_op_valid(i_op_valid),
      .o_op(i_op), .o_src_a(i_src_a), .o_src_b(i_src_b), .o_dst_acc(i_dst_acc),
      .o_add_acc(i_add_acc), .o_sign(i_sign), .o_round(i_round), .o_negate(i_negate),
      .o_shift(i_shift), .o_bus1_wr(i_bus1_wr), .o_bus1_wsel(i_bus1_wsel),
      .o_bus1_wdata(i_bus1_wdata), .o_bus2_wr(i_bus2_wr), .o_bus2_wsel(i_bus2_wsel),
      .o_bus2_wdata(i_bus2_wdata), .o_bus1_rd(i_bus1_rd), .o_bus1_rsel(i_bus1_rsel),
      .o_bus2_rd(i_bus2_rd), .o_bus2_rsel(i_bus2_rsel));
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Bounded wait, the result is normally already there
   task automatic wait_res();
      for (int k = 0; k < 4 && o_result_valid !== 1'b1; k++) seq_u.step();
      `CHK(o_result_valid, 1'b1)
   endtask
   task automatic t_reset();
      `CHK({o_result, o_result_valid, o_bus1_rdata, o_bus2_limited}, 106'h0)
      $display("t_reset done");
   endtask
   task automatic t_load();
      seq_u.wr(1'b0, fmd_pkg::FMD_SEL_OP1_FULL, 48'h400000_600000);
      seq_u.wr(1'b1, fmd_pkg::FMD_SEL_OP2_FULL, 48'h400000_000001);
      seq_u.idle();
      seq_u.rd(fmd_pkg::FMD_SEL_OP1_UPPER, fmd_pkg::FMD_SEL_OP2_LOWER);
      seq_u.idle();
      `CHK(o_bus1_rdata, 48'h000000_400000)
      `CHK(o_bus2_rdata, 48'h000000_000001)
      $display("t_load done");
   endtask
   task automatic t_signs();
      logic [55:0] ex [3];
      logic [3:0]  a;
      logic [3:0]  b;
      ex = '{56'hff_c00000_000000, 56'h00_400000_000000, 56'h00_400000_000000};
      seq_u.wr(1'b0, fmd_pkg::FMD_SEL_OP1_UPPER, 48'h000000_800000);
      seq_u.idle();
      for (int i = 0; i < 3; i++) begin
         a = (i == 2) ? fmd_pkg::FMD_SEL_OP2_UPPER : fmd_pkg::FMD_SEL_OP1_UPPER;
         b = (i == 2) ? fmd_pkg::FMD_SEL_OP1_UPPER : fmd_pkg::FMD_SEL_OP2_UPPER;
         seq_u.op(fmd_pkg::FMD_OP_MPY, a, b, 1'b0, 1'b0, 2'(i), 1'b0, 1'b0);
         seq_u.idle();
         wait_res();
         `CHK(o_result, ex[i])
      end
      $display("t_signs done");
   endtask
   // Multiply then accumulate back to back into the second accumulator
   task automatic t_fwd();
      seq_u.wr(1'b0, fmd_pkg::FMD_SEL_OP1_UPPER, 48'h000000_400000);
      seq_u.idle();
      seq_u.op(fmd_pkg::FMD_OP_MPY, 4'h1, 4'h3, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0);
      seq_u.op(fmd_pkg::FMD_OP_MAC, 4'h1, 4'h3, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0);
      seq_u.idle();
      wait_res();
      `CHK(o_result, 56'h00_400000_000000)
      `CHK(o_result_word, 24'h400000)
      seq_u.rd(fmd_pkg::FMD_SEL_ACC2_FULL, fmd_pkg::FMD_SEL_ACC2_UPPER);
      seq_u.idle();
      `CHK(o_bus1_rdata, 48'h400000_000000)
      `CHK(o_bus2_rdata, 48'h000000_400000)
      `CHK({o_bus1_limited, o_bus2_limited}, 2'b00)
      $display("t_fwd done");
   endtask
   task automatic t_round();
      logic [55:0] ex [3];
      ex = '{56'h00_000000_c00000, 56'h00_000001_000000, 56'hff_ffffff_400000};
      seq_u.wr(1'b0, fmd_pkg::FMD_SEL_OP1_FULL, 48'h400000_600000);
      seq_u.idle();
      for (int i = 0; i < 3; i++) begin
         seq_u.op(fmd_pkg::FMD_OP_MPY, 4'h0, 4'h2, 1'b0, 1'b0, 2'h0, i == 1, i == 2);
         seq_u.idle();
         wait_res();
         `CHK(o_result, ex[i])
         `CHK(o_result_word, ex[i][47:24])
      end
      $display("t_round done");
   endtask
   // Guard field in use: both buses read the same accumulator together
   task automatic t_limit();
      seq_u.wr(1'b0, fmd_pkg::FMD_SEL_ACC1_UPPER, 48'h000000_123456);
      seq_u.wr(1'b0, fmd_pkg::FMD_SEL_ACC1_GUARD, 48'h000000_000001);
      seq_u.idle();
      seq_u.rd(fmd_pkg::FMD_SEL_ACC1_FULL, fmd_pkg::FMD_SEL_ACC1_LOWER);
      seq_u.idle();
      `CHK({o_bus1_limited, o_bus1_rdata}, {1'b1, 48'h7fffff_ffffff})
      `CHK({o_bus2_limited, o_bus2_rdata}, {1'b0, 48'h0})
      seq_u.wr(1'b1, fmd_pkg::FMD_SEL_ACC1_GUARD, 48'h000000_0000fe);
      seq_u.idle();
      seq_u.rd(fmd_pkg::FMD_SEL_ACC1_UPPER, fmd_pkg::FMD_SEL_ACC1_FULL);
      seq_u.idle();
      `CHK({o_bus1_limited, o_bus1_rdata}, {1'b1, 48'h000000_800000})
      `CHK({o_bus2_limited, o_bus2_rdata}, {1'b1, 48'h800000_000000})
      $display("t_limit done");
   endtask
   task automatic t_rereset();
      i_rst_b = 1'b0;
      seq_u.step();
      `CHK({o_result, o_bus1_rdata, o_bus1_limited}, 105'h0)
      i_rst_b = 1'b1;
      seq_u.step();
      $display("t_rereset done");
   endtask
   initial begin
      i_rst_b = 1'b0;
      repeat (8) @(posedge i_clock);
      #1;
      t_reset();
      i_rst_b = 1'b1;
      seq_u.step();
      t_load();
      t_signs();
      t_fwd();
      t_round();
      t_limit();
      t_rereset();
      close_out();
   end
   // Tests need a few hundred cycles at most
   initial begin
      #50000;
      n_errors++;
      close_out();
   end
endmodule
bind fmd_datapath fmd_chk #(.WORD_W(WORD_W), .ACC_W(ACC_W)) chk_u (.*);
